// file: verilog/rxpm_regs.svh
// Register offsets, field positions, reset values and timing values in ns
// Included by the package and the design modules; definitions only
`ifndef RXPM_REGS_SVH
`define RXPM_REGS_SVH

`define RXPM_PORT_SELECT_ADDR     8'h4c
`define RXPM_LINE_LEN_HIGH_ADDR   8'h75
`define RXPM_LINE_LEN_LOW_ADDR    8'h76
`define RXPM_RATE_CTRL_ADDR       8'h77
`define RXPM_MSG_A_ADDR           8'h78
`define RXPM_MSG_B_ADDR           8'h79
`define RXPM_ERR_STATUS_ADDR      8'h7a

`define RXPM_RATE_CTRL_RESET      8'hc5
`define RXPM_MSG_A_RESET          8'h00
`define RXPM_MSG_B_RESET          8'h01
`define RXPM_PORT_SELECT_RESET    8'h01

`define RXPM_HYST_MSB             7
`define RXPM_HYST_LSB             6
`define RXPM_STAB_MSB             5
`define RXPM_STAB_LSB             4
`define RXPM_LOW_MSB              3
`define RXPM_LOW_LSB              0

`define RXPM_ERR_LENGTH_BIT       3
`define RXPM_ERR_CHECKSUM_BIT     2
`define RXPM_ERR_MULTI_BIT        1
`define RXPM_ERR_SINGLE_BIT       0

// Stability windows in nanoseconds, and the clock period
`define RXPM_STAB_TIME0_NS        40000
`define RXPM_STAB_TIME1_NS        80000
`define RXPM_STAB_TIME2_NS        320000
`define RXPM_STAB_TIME3_NS        1280000
`define RXPM_CLK_PERIOD_NS        4

`endif

// file: verilog/rxpm_pkg.sv
// Types shared by the per-port monitor register bank
// Assumes rxpm_regs.svh is on the include path
`include "rxpm_regs.svh"

package rxpm_pkg;

    // Register access strobe from the control-port slave
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rxpm_access_t;

    // Per-port packet error events, one-cycle pulses
    typedef struct packed {
        logic length_mismatch;
        logic payload_checksum;
        logic header_multi;
        logic header_single;
    } rxpm_err_t;

    typedef enum logic [1:0] {
        RXPM_STAB_40US,
        RXPM_STAB_80US,
        RXPM_STAB_320US,
        RXPM_STAB_1280US
    } rxpm_stab_sel_t;

endpackage : rxpm_pkg

// file: verilog/rxpm_rate_monitor.sv
// Clock rate detector for one receive port: hysteresis capture,
// stability timer and low-rate judgement. Runs on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "rxpm_regs.svh"

module rxpm_rate_monitor
    import rxpm_pkg::*;
#(
    parameter int T0_CYCLES = `RXPM_STAB_TIME0_NS / `RXPM_CLK_PERIOD_NS,
    parameter int T1_CYCLES = `RXPM_STAB_TIME1_NS / `RXPM_CLK_PERIOD_NS,
    parameter int T2_CYCLES = `RXPM_STAB_TIME2_NS / `RXPM_CLK_PERIOD_NS,
    parameter int T3_CYCLES = `RXPM_STAB_TIME3_NS / `RXPM_CLK_PERIOD_NS
)
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       sample_valid,
    input  wire logic [7:0] sample_mhz,
    input  wire logic [7:0] control,
    output logic [7:0]      held_mhz,
    output logic            stable,
    output logic            too_slow
);

    logic [7:0]  next_held_mhz;
    logic        next_stable;
    logic        next_too_slow;
    logic [20:0] stab_count;
    logic [20:0] next_stab_count;
    logic [20:0] stab_limit;
    logic [7:0]  diff;
    logic        outside;

    always_comb
    begin
        unique case (rxpm_stab_sel_t'(control[`RXPM_STAB_MSB:`RXPM_STAB_LSB]))
            RXPM_STAB_40US:  stab_limit = 21'(T0_CYCLES); // see (R6)
            RXPM_STAB_80US:  stab_limit = 21'(T1_CYCLES);
            RXPM_STAB_320US: stab_limit = 21'(T2_CYCLES);
            RXPM_STAB_1280US: stab_limit = 21'(T3_CYCLES);
        endcase
        diff = (sample_mhz > held_mhz) ? sample_mhz - held_mhz : held_mhz - sample_mhz;
        outside = diff > {6'h00, control[`RXPM_HYST_MSB:`RXPM_HYST_LSB]}; // see (R4)
        next_held_mhz = held_mhz;
        next_stab_count = stab_count;
        next_stable = stable;
        if (sample_valid && outside)
        begin
            next_held_mhz = sample_mhz; // see (R5)
            next_stab_count = 21'h0;
            next_stable = 1'b0;
        end
        else if (stab_count >= stab_limit - 21'h1)
        begin
            next_stable = 1'b1; // see (R6)
        end
        else
        begin
            next_stab_count = stab_count + 21'h1;
        end
        next_too_slow = next_held_mhz < {4'h0, control[`RXPM_LOW_MSB:`RXPM_LOW_LSB]}; // see (R7)
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            held_mhz <= 8'h00;
            stab_count <= 21'h0;
            stable <= 1'b0;
            too_slow <= 1'b1;
        end
        else if (clk_en)
        begin
            held_mhz <= next_held_mhz;
            stab_count <= next_stab_count;
            stable <= next_stable;
            too_slow <= next_too_slow;
        end
    end

endmodule : rxpm_rate_monitor
`default_nettype wire

// file: verilog/rxpm_port_regs.sv
// Registers of one receive port: line length freeze and latch,
// rate control, two message bytes, sticky packet error flags.
`timescale 1ns/1ps
`default_nettype none
`include "rxpm_regs.svh"

module rxpm_port_regs
    import rxpm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         selected,
    input  wire rxpm_access_t acc,
    input  wire logic         line_irq_enable,
    input  wire logic         line_valid,
    input  wire logic [15:0]  line_length,
    input  wire rxpm_err_t    err,
    output logic [7:0]        rate_control,
    output logic [7:0]        rdata
);

    logic [15:0] shown_len;
    logic [15:0] next_shown_len;
    logic [7:0]  low_latch;
    logic [7:0]  next_low_latch;
    logic        frozen;
    logic        next_frozen;
    logic [7:0]  next_rate_control;
    logic [7:0]  msg_a;
    logic [7:0]  next_msg_a;
    logic [7:0]  msg_b;
    logic [7:0]  next_msg_b;
    logic [3:0]  err_flags;
    logic [3:0]  next_err_flags;
    logic        rd_sel;
    logic        wr_sel;

    always_comb
    begin
        rd_sel = acc.rd && selected; // see (R14)
        wr_sel = acc.wr && selected;
        next_shown_len = shown_len;
        next_frozen = frozen;
        next_low_latch = low_latch;
        if (line_valid && !(line_irq_enable && frozen))
        begin
            next_shown_len = line_length; // see (R1)
            next_frozen = 1'b1;
        end
        if (rd_sel && acc.addr == `RXPM_LINE_LEN_HIGH_ADDR)
        begin
            next_low_latch = shown_len[7:0]; // see (R3)
        end
        if (rd_sel && acc.addr == `RXPM_LINE_LEN_LOW_ADDR)
        begin
            next_frozen = 1'b0; // see (R2)
        end
        if (!line_irq_enable)
        begin
            next_frozen = 1'b0;
        end
        next_rate_control = rate_control;
        next_msg_a = msg_a;
        next_msg_b = msg_b;
        if (wr_sel)
        begin
            unique case (acc.addr)
                `RXPM_RATE_CTRL_ADDR: next_rate_control = acc.wdata;
                `RXPM_MSG_A_ADDR:     next_msg_a = acc.wdata; // see (R8)
                `RXPM_MSG_B_ADDR:     next_msg_b = acc.wdata;
                default:              next_msg_a = msg_a;
            endcase
        end
        next_err_flags = err_flags;
        if (rd_sel && acc.addr == `RXPM_ERR_STATUS_ADDR)
        begin
            next_err_flags = 4'h0; // see (R13)
        end
        // Set wins over the read clear
        next_err_flags[`RXPM_ERR_LENGTH_BIT]   = next_err_flags[`RXPM_ERR_LENGTH_BIT]
                                               | err.length_mismatch; // see (R9) (R16)
        next_err_flags[`RXPM_ERR_CHECKSUM_BIT] = next_err_flags[`RXPM_ERR_CHECKSUM_BIT]
                                               | err.payload_checksum; // see (R10)
        next_err_flags[`RXPM_ERR_MULTI_BIT]    = next_err_flags[`RXPM_ERR_MULTI_BIT]
                                               | err.header_multi; // see (R11)
        next_err_flags[`RXPM_ERR_SINGLE_BIT]   = next_err_flags[`RXPM_ERR_SINGLE_BIT]
                                               | err.header_single; // see (R12)
        unique case (acc.addr)
            `RXPM_LINE_LEN_HIGH_ADDR: rdata = shown_len[15:8];
            `RXPM_LINE_LEN_LOW_ADDR:  rdata = low_latch;
            `RXPM_RATE_CTRL_ADDR:     rdata = rate_control;
            `RXPM_MSG_A_ADDR:         rdata = msg_a;
            `RXPM_MSG_B_ADDR:         rdata = msg_b;
            `RXPM_ERR_STATUS_ADDR:    rdata = {4'h0, err_flags};
            default:                  rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shown_len <= 16'h0000;
            low_latch <= 8'h00;
            frozen <= 1'b0;
            rate_control <= `RXPM_RATE_CTRL_RESET;
            msg_a <= `RXPM_MSG_A_RESET;
            msg_b <= `RXPM_MSG_B_RESET;
            err_flags <= 4'h0;
        end
        else if (clk_en)
        begin
            shown_len <= next_shown_len;
            low_latch <= next_low_latch;
            frozen <= next_frozen;
            rate_control <= next_rate_control;
            msg_a <= next_msg_a;
            msg_b <= next_msg_b;
            err_flags <= next_err_flags;
        end
    end

endmodule : rxpm_port_regs
`default_nettype wire

// file: verilog/rxpm_monitor_top.sv
// Notes on behaviour
// (R1) Line length shows most recent line
// (R2) Interrupt enable freezes length until read
// (R3) High byte read latches low byte
// (R4) Two-bit hysteresis in MHz, default three
// (R5) Capture frequency only beyond hysteresis
// (R6) Stable after selectable time, default 40us
// (R7) Below four-bit low limit means too slow
// (R8) Two free message bytes, reset 0, 1
// (R9) Bit 3: header length mismatch
// (R10) Bit 2: payload checksum failure
// (R11) Bit 1: multi-bit header error, uncorrected
// (R12) Bit 0: single-bit header error, corrected; header_fixed passes the byte through unchanged
// (R13) Error bits sticky, clear on read
// (R14) Port select routes access to one copy; every port whose port_select bit is set takes the access
// (R15) Error status sits at offset 7a
// (R16) New error during clear stays set
//
// Top of the per-port receive monitor register bank.
// Assumes a control-port slave that issues one-cycle register strobes
// and samples read data one cycle after a read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "rxpm_regs.svh"

module rxpm_monitor_top
    import rxpm_pkg::*;
#(
    parameter int PORTS = 2
)
(
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    input  wire rxpm_pkg::rxpm_access_t acc,
    input  wire logic                  line_irq_enable,
    input  wire logic [PORTS-1:0]      line_valid,
    input  wire logic [PORTS*16-1:0]   line_length,
    input  wire rxpm_pkg::rxpm_err_t [PORTS-1:0] err,
    input  wire logic [PORTS-1:0]      rate_sample_valid,
    input  wire logic [PORTS*8-1:0]    rate_sample_mhz,
    input  wire logic [PORTS*8-1:0]    header_in,
    output logic [7:0]                 rdata,
    output logic [PORTS*8-1:0]         header_fixed,
    output logic [PORTS-1:0]           clock_stable,
    output logic [PORTS-1:0]           clock_too_slow,
    output logic [PORTS*8-1:0]         clock_rate_mhz
);

    logic             rst_meta;
    logic             rst_n;
    logic [7:0]       port_select;
    logic [7:0]       next_port_select;
    logic [7:0]       next_rdata;
    logic [7:0]       port_rdata [PORTS];
    logic [7:0]       port_rate_ctrl [PORTS];
    logic [PORTS*8-1:0] next_header_fixed;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    genvar p;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            rxpm_port_regs u_regs (
                .core_clk        (core_clk),
                .rst_n           (rst_n),
                .clk_en          (clk_en),
                .selected        (port_select[p]), // see (R14)
                .acc             (acc),
                .line_irq_enable (line_irq_enable),
                .line_valid      (line_valid[p]),
                .line_length     (line_length[p*16 +: 16]),
                .err             (err[p]),
                .rate_control    (port_rate_ctrl[p]),
                .rdata           (port_rdata[p])
            );
            rxpm_rate_monitor u_rate (
                .core_clk     (core_clk),
                .rst_n        (rst_n),
                .clk_en       (clk_en),
                .sample_valid (rate_sample_valid[p]),
                .sample_mhz   (rate_sample_mhz[p*8 +: 8]),
                .control      (port_rate_ctrl[p]),
                .held_mhz     (clock_rate_mhz[p*8 +: 8]),
                .stable       (clock_stable[p]),
                .too_slow     (clock_too_slow[p])
            );
        end
    endgenerate

    always_comb
    begin
        next_port_select = port_select;
        if (acc.wr && acc.addr == `RXPM_PORT_SELECT_ADDR)
        begin
            next_port_select = acc.wdata;
        end
        next_rdata = 8'h00;
        if (acc.rd)
        begin
            if (acc.addr == `RXPM_PORT_SELECT_ADDR)
            begin
                next_rdata = port_select;
            end
            else
            begin
                // Lowest selected port answers
                for (int i = PORTS - 1; i >= 0; i--)
                begin
                    if (port_select[i])
                    begin
                        next_rdata = port_rdata[i]; // see (R14) (R15)
                    end
                end
            end
        end
        // Single-bit header errors pass the header byte through unchanged
        next_header_fixed = header_in;
        for (int i = 0; i < PORTS; i++)
        begin
            if (err[i].header_single) // see (R12)
            begin
                next_header_fixed[i*8 +: 8] = header_in[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_select <= `RXPM_PORT_SELECT_RESET;
            rdata <= 8'h00;
            header_fixed <= '0;
        end
        else if (clk_en)
        begin
            port_select <= next_port_select;
            rdata <= next_rdata;
            header_fixed <= next_header_fixed;
        end
    end

endmodule : rxpm_monitor_top
`default_nettype wire

// file: verification/rxpm_monitor_props.sv
// Assertion checker for the receive port monitor register bank
// Sees only the top module's ports; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module rxpm_monitor_props
    import rxpm_pkg::*;
#(
    parameter int PORTS = 2
)
(
    input wire logic                           core_clk,
    input wire logic                           reset_n,
    input wire logic                           clk_en,
    input wire rxpm_pkg::rxpm_access_t         acc,
    input wire rxpm_pkg::rxpm_err_t [PORTS-1:0] err,
    input wire logic [PORTS-1:0]               rate_sample_valid,
    input wire logic [PORTS*8-1:0]             header_in,
    input wire logic [7:0]                     rdata,
    input wire logic [PORTS*8-1:0]             header_fixed,
    input wire logic [PORTS-1:0]               clock_stable,
    input wire logic [PORTS*8-1:0]             clock_rate_mhz
);
    // Counts edges since reset release; the design's own reset lags by two flops
    logic [1:0] up;
    logic [1:0] next_up;

    always_comb next_up = (up == 2'h3) ? up : up + 2'h1;

    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n) up <= 2'h0;
        else up <= next_up;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_rdst;
        up == 2'h3 && clk_en && acc.rd && acc.addr == 8'h7a && err == '0;
    endsequence

    a_rdata_idle: assert property (up == 2'h3 && clk_en && !acc.rd |=> rdata == 8'h00)
        else $error("read data not idle");
    a_status_upper: assert property (up == 2'h3 && clk_en && acc.rd && acc.addr == 8'h7a |=> rdata[7:4] == 4'h0)
        else $error("status upper bits set");
    a_status_clear: assert property (s_rdst ##1 s_rdst |=> rdata == 8'h00)
        else $error("status not cleared by read");
    a_unmapped_zero: assert property (up == 2'h3 && clk_en && acc.rd && acc.addr == 8'h80 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_msg_echo: assert property (up == 2'h3 && clk_en && acc.wr && acc.addr == 8'h78 ##1
        clk_en && acc.rd && acc.addr == 8'h78 |=> rdata == $past(acc.wdata, 2))
        else $error("message byte not echoed");
    a_rate_cause: assert property (up == 2'h3 && !$stable(clock_rate_mhz[7:0])
        |-> $past(rate_sample_valid[0]) || $past(rate_sample_valid[0], 2))
        else $error("rate changed without sample");
    a_stable_drop: assert property (up == 2'h3 && !$stable(clock_rate_mhz[7:0]) |-> ##[0:2] !clock_stable[0])
        else $error("stable kept across change");
    a_fixed_pass: assert property (up == 2'h3 && clk_en |=> header_fixed == $past(header_in))
        else $error("header byte not passed");

    c_clear_pair: cover property (s_rdst ##1 s_rdst);
    c_stable: cover property ($rose(clock_stable[0]));
    c_select: cover property (clk_en && acc.wr && acc.addr == 8'h4c);
endmodule : rxpm_monitor_props

bind rxpm_monitor_top rxpm_monitor_props #(.PORTS(PORTS)) u_props (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .acc(acc), .err(err),
    .rate_sample_valid(rate_sample_valid), .header_in(header_in), .rdata(rdata),
    .header_fixed(header_fixed), .clock_stable(clock_stable), .clock_rate_mhz(clock_rate_mhz)
);

`default_nettype wire

// file: verification/rxpm_host_model.sv
// Control-port host model issuing one-cycle register strobes
// Assumes each call starts 1 ns after a rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none

module rxpm_host_model
    import rxpm_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic [7:0]           rdata,
    output var rxpm_pkg::rxpm_access_t acc
);
    initial acc = '0;

    // Hold keeps the bus busy so the next call follows back to back
    task op(input logic w, input logic [7:0] a, input logic [7:0] d, input bit hold, output logic [7:0] r);
        acc = '{w, !w, a, d};
        @(posedge core_clk);
        #1;
        r = rdata;
        if (!hold)
        begin
            acc = '0;
            @(posedge core_clk);
            #1;
        end
    endtask : op
endmodule : rxpm_host_model

`default_nettype wire

// file: verification/rxpm_monitor_test.sv
// Self-checking bench for the receive port monitor register bank
// Assumes the host model drives all register strobes
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end

module rxpm_monitor_test
    import rxpm_pkg::*;
;
    logic                 core_clk = 1'b0;
    logic                 reset_n;
    logic                 clk_en;
    rxpm_access_t         acc;
    logic                 line_irq_enable;
    logic [1:0]           line_valid;
    logic [31:0]          line_length;
    rxpm_err_t [1:0]      err;
    logic [1:0]           rate_sample_valid;
    logic [15:0]          rate_sample_mhz;
    logic [15:0]          header_in = 16'h5aa5;
    logic [7:0]           rdata;
    logic [15:0]          header_fixed;
    logic [1:0]           clock_stable;
    logic [1:0]           clock_too_slow;
    logic [15:0]          clock_rate_mhz;
    logic [7:0]           r;
    int                   err_total;
    int                   num_checks;

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) header_in <= #1 header_in + 16'h0101;

    rxpm_host_model host (.core_clk(core_clk), .rdata(rdata), .acc(acc));

    rxpm_monitor_top #(.PORTS(2)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .acc(acc),
        .line_irq_enable(line_irq_enable), .line_valid(line_valid), .line_length(line_length),
        .err(err), .rate_sample_valid(rate_sample_valid), .rate_sample_mhz(rate_sample_mhz),
        .header_in(header_in), .rdata(rdata), .header_fixed(header_fixed),
        .clock_stable(clock_stable), .clock_too_slow(clock_too_slow), .clock_rate_mhz(clock_rate_mhz)
    );

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.op(1'b1, a, d, 1'b0, r);
    endtask : wr

    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        host.op(1'b0, a, 8'h00, 1'b0, r);
        `CHK(n, e, r)
    endtask : rdc

    task automatic line(input logic [15:0] v);
        line_length[15:0] = v;
        line_valid[0] = 1'b1;
        @(posedge core_clk);
        #1;
        line_valid[0] = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : line

    task automatic sample(input logic [7:0] v);
        rate_sample_mhz[7:0] = v;
        rate_sample_valid[0] = 1'b1;
        @(posedge core_clk);
        #1;
        rate_sample_valid[0] = 1'b0;
        repeat (3)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask : sample

    task automatic wait_stable(input int n);
        int c;
        for (c = 4; c < n + 40 && clock_stable[0] !== 1'b1; c++)
        begin
            @(posedge core_clk);
            #1;
        end
        `CHK("stable time", 1'b1, (c >= n - 6 && c <= n + 6))
        if (clock_stable[0] !== 1'b1)
        begin
            complete_run();
        end
    endtask : wait_stable

    task automatic t_defaults;
        rdc("rate ctl", 8'h77, 8'hc5);
        rdc("msg a", 8'h78, 8'h00);
        rdc("msg b", 8'h79, 8'h01);
        rdc("status", 8'h7a, 8'h00);
        wr(8'h80, 8'hff);
        rdc("unmapped", 8'h80, 8'h00);
        rdc("len hi", 8'h75, 8'h00);
    endtask : t_defaults

    task automatic t_ports;
        wr(8'h78, 8'ha5);
        wr(8'h4c, 8'h02);
        rdc("p1 msg a", 8'h78, 8'h00);
        wr(8'h79, 8'h3c);
        rdc("p1 msg b", 8'h79, 8'h3c);
        wr(8'h4c, 8'h01);
        rdc("p0 msg b", 8'h79, 8'h01);
        host.op(1'b1, 8'h78, 8'h5e, 1'b1, r);
        rdc("p0 msg a", 8'h78, 8'h5e);
    endtask : t_ports

    task automatic t_errors;
        for (int i = 0; i < 4; i++)
        begin
            err[0] = rxpm_err_t'(4'h1 << i);
            err[1] = rxpm_err_t'(4'hf);
            @(posedge core_clk);
            #1;
            err = '0;
            rdc("flag", 8'h7a, 8'h01 << i);
            rdc("cleared", 8'h7a, 8'h00);
        end
        wr(8'h4c, 8'h02);
        rdc("p1 flags", 8'h7a, 8'h0f);
        wr(8'h4c, 8'h01);
        err[0] = rxpm_err_t'(4'h2);
        host.op(1'b0, 8'h7a, 8'h00, 1'b1, r);
        err = '0;
        rdc("kept", 8'h7a, 8'h02);
        host.op(1'b0, 8'h7a, 8'h00, 1'b1, r);
        rdc("empty", 8'h7a, 8'h00);
    endtask : t_errors

    task automatic t_line;
        line(16'h1234);
        rdc("len hi", 8'h75, 8'h12);
        rdc("len lo", 8'h76, 8'h34);
        line(16'h5678);
        rdc("len hi", 8'h75, 8'h56);
        line(16'h9abc);
        rdc("latched lo", 8'h76, 8'h78);
        line_irq_enable = 1'b1;
        line(16'hcdef);
        line(16'h0102);
        rdc("frozen hi", 8'h75, 8'hcd);
        rdc("frozen lo", 8'h76, 8'hef);
        line(16'h0304);
        rdc("fresh hi", 8'h75, 8'h03);
        rdc("fresh lo", 8'h76, 8'h04);
        line_irq_enable = 1'b0;
    endtask : t_line

    task automatic t_rate;
        sample(8'h10);
        `CHK("rate", 8'h10, clock_rate_mhz[7:0])
        sample(8'h13);
        `CHK("rate hyst", 8'h10, clock_rate_mhz[7:0])
        sample(8'h14);
        `CHK("rate", 8'h14, clock_rate_mhz[7:0])
        wr(8'h77, 8'h45);
        sample(8'h03);
        `CHK("slow", 1'b1, clock_too_slow[0])
        sample(8'h05);
        `CHK("not slow", 1'b0, clock_too_slow[0])
        sample(8'h06);
        `CHK("rate hyst", 8'h05, clock_rate_mhz[7:0])
        sample(8'h30);
        wait_stable(10000);
        wr(8'h77, 8'h55);
        sample(8'h40);
        wait_stable(20000);
    endtask : t_rate

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        line_irq_enable = 1'b0;
        line_valid = '0;
        line_length = '0;
        err = '0;
        rate_sample_valid = '0;
        rate_sample_mhz = '0;
        err_total = 0;
        num_checks = 0;
        repeat (6) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        t_defaults();
        t_ports();
        t_errors();
        t_line();
        t_rate();
        complete_run();
    end
endmodule : rxpm_monitor_test

`default_nettype wire
